/* File: hdl/epdsp_serial_write_port.sv */
// Purpose: write-only serial host port, 4-wire or 3-wire 9-bit
// Assumes: link clock at most 8 MHz, sampled by 100 MHz system clock
// Notes: words leave through a two-entry buffer toward ram/command sinks
// Operation
// - only 4-wire and 3-wire serial modes
// - serial clock shifts, serial line carries data
// - 4-wire: eight bits msb first per rising edge
// - 4-wire: eighth edge samples d/c, writes byte
// - write only, no read-back path
// - 3-wire: nine bits, flag first, ninth completes
// - 3-wire: flag one data, zero command
// - 3-wire: d/c pin ignored, host ties low
// - 4-wire: d/c high data, low command
// - transfers only while chip select low
// - select low 4-wire, high 3-wire
`timescale 1ns/1ps
module epdsp_serial_write_port
   import epdsp_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // host pins, asynchronous
   input wire logic i_interface_select_pin,
   input wire logic i_chip_select_low,
   input wire logic i_serial_clock,
   input wire logic i_serial_input_line,
   input wire logic i_data_command,
   input wire logic i_hardware_reset_low,
   // busy level from the controller core
   input wire logic i_core_busy,
   output logic o_busy_indicator_low,
   // received words
   output logic o_word_valid,
   input wire logic i_word_ready,
   output epdsp_word_s o_word,
   // status
   output logic o_overrun,
   output epdsp_mode_e o_mode
);
   logic [5:0] pins_sync;
   logic sclk_s;
   logic csn_s;
   logic serial_input_line_s;
   logic dc_s;
   logic sel_s;
   logic sclk_prev;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [8:0] shreg;
   logic [8:0] next_shreg;
   logic flag3;
   logic push_valid;
   logic push_ready;
   epdsp_word_s push_word;
   epdsp_word_s next_push_word;
   logic next_push_valid;
   logic overrun;
   epdsp_mode_e mode;
   wire rise;
   wire active;
   wire last_bit;
   wire [3:0] word_len;
   wire core_reset;
   wire busy_block;

   // all pins cross through two flops before use
   epdsp_sync #(
      .WIDTH(6)
   ) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_hardware_reset_low, i_interface_select_pin, i_data_command,
                i_serial_input_line, i_chip_select_low, i_serial_clock}),
      .o_sync(pins_sync)
   );

   // pin unpacking
   assign sclk_s = pins_sync[0];
   assign csn_s = pins_sync[1];
   assign serial_input_line_s = pins_sync[2];
   assign dc_s = pins_sync[3];
   assign sel_s = pins_sync[4];

   // edge and framing decode; sclk is slow so edges are never missed
   // reset pin is synchronised too; it reads as held low just after reset
   assign core_reset = ~pins_sync[5];
   assign active = ~csn_s;
   assign rise = active && sclk_s && !sclk_prev;
   assign word_len = (mode == EPDSP_MODE_3WIRE) ? EPDSP_WORD3_BITS[3:0]
                                                : EPDSP_WORD4_BITS[3:0];
   assign last_bit = rise && (bit_cnt == word_len - 4'h1);
   // a frame started while busy is still accepted; the host owns that wait
   assign busy_block = 1'b0;

   // mode latched only when idle, so a mid-frame glitch cannot split a word
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         mode <= EPDSP_MODE_4WIRE;
      else if (!active)
         mode <= sel_s ? EPDSP_MODE_3WIRE : EPDSP_MODE_4WIRE;
   end

   // shifter and counter next values
   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      if (!active || core_reset)
      begin
         next_bit_cnt = EPDSP_CNT_RESET;
         next_shreg = '0;
      end
      else if (rise)
      begin
         next_shreg = {shreg[7:0], serial_input_line_s};
         next_bit_cnt = last_bit ? EPDSP_CNT_RESET : bit_cnt + 4'h1;
      end
   end

   // 3-wire flag is the first bit of the word
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         flag3 <= 1'b0;
      else if (rise && bit_cnt == EPDSP_CNT_RESET)
         flag3 <= serial_input_line_s;
   end

   // word assembly at the final edge
   always_comb
   begin
      next_push_word = push_word;
      next_push_valid = push_valid && !push_ready;
      if (last_bit && !busy_block && !core_reset)
      begin
         next_push_valid = 1'b1;
         next_push_word.value = {shreg[6:0], serial_input_line_s};
         if (mode == EPDSP_MODE_3WIRE)
            next_push_word.is_data = flag3;
         else
            next_push_word.is_data = dc_s;
      end
   end

   // state registers
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         sclk_prev <= 1'b0;
         bit_cnt <= EPDSP_CNT_RESET;
         shreg <= '0;
         push_valid <= 1'b0;
         push_word <= EPDSP_WORD_RESET;
      end
      else
      begin
         sclk_prev <= sclk_s;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         push_valid <= next_push_valid;
         push_word <= next_push_word;
      end
   end

   // sticky overrun: a word completed while the staging slot was still held
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         overrun <= 1'b0;
      else if (last_bit && push_valid && !push_ready)
         overrun <= 1'b1;
      else if (core_reset)
         overrun <= 1'b0;
   end

   // two-entry buffer absorbs receiver stalls; no read path exists
   epdsp_fifo #(
      .WIDTH($bits(epdsp_word_s)),
      .DEPTH(EPDSP_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(push_valid),
      .o_in_ready(push_ready),
      .i_in_data(push_word),
      .o_out_valid(o_word_valid),
      .i_out_ready(i_word_ready),
      .o_out_data(o_word)
   );

   // status outputs, busy pin low while core busy
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_busy_indicator_low <= 1'b1;
      else
         o_busy_indicator_low <= ~i_core_busy;
   end
   assign o_overrun = overrun;
   assign o_mode = mode;
endmodule

/* File: hdl/epdsp_pkg.sv */
// Purpose: shared constants and types for the serial write port
// Assumes: one system clock at 100 MHz
// Notes: word carrier holds one received byte with its routing flag
package epdsp_pkg;
   localparam int unsigned EPDSP_CLK_MHZ = 100;
   localparam int unsigned EPDSP_BYTE_BITS = 8;
   localparam int unsigned EPDSP_WORD4_BITS = 8;
   localparam int unsigned EPDSP_WORD3_BITS = 9;
   localparam int unsigned EPDSP_SYNC_STAGES = 2;
   localparam int unsigned EPDSP_FIFO_DEPTH = 2;
   localparam logic [3:0] EPDSP_CNT_RESET = 4'h0;
   localparam logic [7:0] EPDSP_BYTE_RESET = 8'h00;
   // display data when set, command when clear
   typedef struct packed
   {
      logic is_data;
      logic [7:0] value;
   } epdsp_word_s;
   localparam epdsp_word_s EPDSP_WORD_RESET = '{is_data: 1'b0, value: 8'h00};
   typedef enum logic [0:0]
   {
      EPDSP_MODE_4WIRE = 1'b0,
      EPDSP_MODE_3WIRE = 1'b1
   } epdsp_mode_e;
endpackage

/* File: hdl/epdsp_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: stage one feeds only stage two
`timescale 1ns/1ps
module epdsp_sync
   import epdsp_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // async levels in, synchronous out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;
   // double registering for metastability
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         stage1 <= '0;
         o_sync <= '0;
      end
      else
      begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule

/* File: hdl/epdsp_fifo.sv */
// Purpose: small valid/ready buffer for received words
// Assumes: depth is a power of two
// Notes: full stalls writer, so the writer must drop or hold
`timescale 1ns/1ps
module epdsp_fifo
   import epdsp_pkg::*;
#(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = EPDSP_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire do_wr;
   wire do_rd;
   wire [AW:0] fill;
   // occupancy decode
   assign fill = wr_ptr - rd_ptr;
   assign o_in_ready = (fill != DEPTH[AW:0]);
   assign o_out_valid = (fill != '0);
   assign do_wr = i_in_valid && o_in_ready;
   assign do_rd = o_out_valid && i_out_ready;
   assign o_out_data = mem[rd_ptr[AW-1:0]];
   // pointers
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
   // storage, no reset needed for data
   always_ff @(posedge i_clk)
   begin
      if (do_wr)
         mem[wr_ptr[AW-1:0]] <= i_in_data;
   end
endmodule

/* File: dv/epdsp_port_chk_assertions.sv */
// Purpose: port assertions for the serial write port
// Assumes: sees top ports only
// Notes: mode checks allow six clocks of pin sync
`timescale 1ns/1ps
module epdsp_port_chk
   import epdsp_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // pins
   input wire logic i_interface_select_pin,
   input wire logic i_chip_select_low,
   input wire logic i_serial_clock,
   input wire logic i_serial_input_line,
   input wire logic i_data_command,
   input wire logic i_hardware_reset_low,
   input wire logic i_core_busy,
   input wire logic i_word_ready,
   // outputs
   input wire logic o_busy_indicator_low,
   input wire logic o_word_valid,
   input wire epdsp_word_s o_word,
   input wire logic o_overrun,
   input wire epdsp_mode_e o_mode
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // idle link with a steady select level
   sequence s_idle(logic s);
      (i_chip_select_low && i_interface_select_pin == s)[*6];
   endsequence
   // held reset must show idle outputs
   reset_vals_a:
      assert property (disable iff (1'b0) i_sys_rst |-> !o_word_valid && !o_overrun)
      else $error("outputs off reset values");
   mode_three_a:
      assert property (s_idle(1'b1) |-> o_mode == EPDSP_MODE_3WIRE) else $error("mode not 3w");
   mode_four_a:
      assert property (s_idle(1'b0) |-> o_mode == EPDSP_MODE_4WIRE) else $error("mode not 4w");
   mode_frozen_a:
      assert property ((!i_chip_select_low)[*6] |-> $stable(o_mode)) else $error("mode moved");
   word_hold_a:
      assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
      else $error("word dropped before taken");
   cs_quiet_a:
      assert property (i_chip_select_low[*8] |-> !$rose(o_overrun)) else $error("word while idle");
   busy_follow_a:
      assert property (o_busy_indicator_low == !$past(i_core_busy)) else $error("busy mismatch");
   hw_clear_a:
      assert property ((!i_hardware_reset_low)[*4] |-> !o_overrun) else $error("overrun kept");
endmodule
bind epdsp_serial_write_port epdsp_port_chk i_chk (.*);

/* File: dv/epdsp_host.sv */
// Purpose: host master model driving the link pins
// Assumes: link clock 125 ns, idle low between frames
// Notes: n below a full word leaves a partial frame
`timescale 1ns/1ps
module epdsp_host
(
   // link pins
   output logic o_csb,
   output logic o_sclk,
   output logic o_serial_input_line,
   output logic o_dc
);
   initial
   begin
      o_csb = 1'b1;
      o_sclk = 1'b0;
      o_serial_input_line = 1'b0;
      o_dc = 1'b0;
   end
   // one frame, msb first; write only, nothing read back
   task automatic xfer(input logic m3, input logic d, input logic [7:0] b, input int n);
      logic [8:0] w;
      w = m3 ? {d, b} : {b, 1'b0};
      o_dc = m3 ? 1'b0 : d;
      o_csb = 1'b0;
      #150;
      for (int i = 8; i > 8 - n; i--)
      begin
         o_serial_input_line = w[i];
         #62.5 o_sclk = 1'b1;
         #62.5 o_sclk = 1'b0;
      end
      #65 o_csb = 1'b1;
      o_serial_input_line = ~o_serial_input_line; // released line must not keep its last value
      #300;
   endtask
endmodule

/* File: dv/tb.sv */
// Purpose: self-checking bench for the serial write port
// Assumes: host model owns the four link pins
// Notes: stalled sink forces an overrun
`timescale 1ns/1ps
module tb
   import epdsp_pkg::*;
;
   logic i_clk, i_sys_rst, i_interface_select_pin, i_hardware_reset_low;
   logic i_core_busy, i_word_ready, o_busy_indicator_low, o_word_valid, o_overrun;
   wire logic i_chip_select_low, i_serial_clock, i_serial_input_line, i_data_command;
   epdsp_word_s o_word;
   epdsp_mode_e o_mode;
   int n_mismatch = 0;
   int checks = 0;
   // rows: select, flag, byte
   logic [9:0] rows [6] = '{10'h0A5, 10'h13C, 10'h281, 10'h37E, 10'h100, 10'h3FF};
   epdsp_serial_write_port i_epdsp_serial_write_port (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_interface_select_pin(i_interface_select_pin),
      .i_chip_select_low(i_chip_select_low),
      .i_serial_clock(i_serial_clock),
      .i_serial_input_line(i_serial_input_line),
      .i_data_command(i_data_command),
      .i_hardware_reset_low(i_hardware_reset_low),
      .i_core_busy(i_core_busy),
      .o_busy_indicator_low(o_busy_indicator_low),
      .o_word_valid(o_word_valid),
      .i_word_ready(i_word_ready),
      .o_word(o_word),
      .o_overrun(o_overrun),
      .o_mode(o_mode)
   );
   epdsp_host i_epdsp_host (.o_csb(i_chip_select_low), .o_sclk(i_serial_clock),
      .o_serial_input_line(i_serial_input_line), .o_dc(i_data_command));
   // system clock
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic wrap_up();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   // bounded wait for a word, then pop it
   task automatic get_word(input logic [8:0] exp);
      int k;
      // step off the edge so a pop at this edge has settled
      #1;
      for (k = 0; k < 100 && o_word_valid !== 1'b1; k++)
      begin
         @(posedge i_clk);
         #1;
      end
      if (k == 100)
      begin
         n_mismatch++;
         wrap_up();
      end
      else
      begin
         cmp("word", exp, o_word);
         @(posedge i_clk) i_word_ready <= 1'b1;
         @(posedge i_clk) i_word_ready <= 1'b0;
      end
   endtask
   initial
   begin
      i_sys_rst = 1'b1;
      i_interface_select_pin = 1'b0;
      i_hardware_reset_low = 1'b1;
      i_core_busy = 1'b0;
      i_word_ready = 1'b0;
      repeat (10) @(posedge i_clk);
      cmp("reset", 9'h001, {o_word_valid, o_overrun, o_mode, 5'h00, o_busy_indicator_low});
      i_sys_rst <= 1'b0;
      foreach (rows[r])
      begin
         @(posedge i_clk) i_interface_select_pin <= rows[r][9];
         repeat (6) @(posedge i_clk);
         #1;
         cmp("mode", {8'h00, rows[r][9]}, {8'h00, o_mode});
         i_epdsp_host.xfer(rows[r][9], rows[r][8], rows[r][7:0], rows[r][9] ? 9 : 8);
         get_word(rows[r][8:0]);
      end
      // aborted frame leaves nothing behind
      @(posedge i_clk) i_interface_select_pin <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_epdsp_host.xfer(1'b0, 1'b1, 8'h5A, 5);
      i_epdsp_host.xfer(1'b0, 1'b0, 8'hC3, 8);
      get_word(9'h0C3);
      // staging plus buffer hold three, the fourth overwrites staging
      for (int b = 1; b <= 4; b++)
         i_epdsp_host.xfer(1'b0, 1'b0, 8'(b * 17), 8);
      cmp("overrun", 9'h001, {8'h00, o_overrun});
      get_word(9'h011);
      get_word(9'h022);
      get_word(9'h044);
      @(posedge i_clk) i_hardware_reset_low <= 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
      cmp("idle", 9'h000, {7'h00, o_word_valid, o_overrun});
      @(posedge i_clk) i_core_busy <= 1'b1;
      i_hardware_reset_low <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      cmp("busy", 9'h000, {8'h00, o_busy_indicator_low});
      wrap_up();
   end
endmodule
